// ### logic/sbr_pkg.sv
// package: base register map, field layout, reset values and timing of the phy base bank
package sbr_pkg;

	// ----------
	// register indices (printed offsets are 0..7, byte address = 4*index)
	// ----------
	localparam logic [2:0] IDX_NODE_IDENTITY_STATUS    = 3'h0;
	localparam logic [2:0] IDX_RESET_GAP_CONTROL       = 3'h1;
	localparam logic [2:0] IDX_CAPABILITY_PORTS        = 3'h2;
	localparam logic [2:0] IDX_SPEED_STANDBY_DELAY     = 3'h3;
	localparam logic [2:0] IDX_LINK_CONTENDER_POWER    = 3'h4;
	localparam logic [2:0] IDX_INTERRUPT_EVENT_CONTROL = 3'h5;
	localparam logic [2:0] IDX_LEGACY_SPEED_BRIDGE     = 3'h6;
	localparam logic [2:0] IDX_PAGE_PORT_SELECT        = 3'h7;
	localparam int         ADDR_WIDTH                  = 6;
	localparam int         REG_COUNT                   = 8;
	localparam logic [5:0] ADDR_PAGED_BASE             = 6'h20;

	// ----------
	// field positions, in hardware bit order (documented bit 0 = msb, bit 7)
	// ----------
	localparam int POS_CABLE_POWER_STATUS      = 0;
	localparam int POS_ROOT                    = 1;
	localparam int POS_NODE_PHYS_ADDRESS       = 2;
	localparam int POS_GAP_COUNT               = 0;
	localparam int POS_LONG_BUS_RESET_REQUEST  = 6;
	localparam int POS_ROOT_HOLDOFF            = 7;
	localparam int POS_PORT_COUNT              = 0;
	localparam int POS_EXTENDED_SET            = 5;
	localparam int POS_REPEATER_DELAY          = 0;
	localparam int POS_STANDBY_RESTORE_ENABLE  = 4;
	localparam int POS_LEGACY_SPEED_CODE       = 5;
	localparam int POS_PAGE_SELECT             = 5;
	localparam int POS_PORT_SELECT             = 0;

	// ----------
	// fixed read values and reset values
	// ----------
	localparam logic [2:0] EXTENDED_SET_CODE   = 3'h7;
	localparam logic [3:0] PORT_COUNT_CODE     = 4'h3;
	localparam logic [2:0] LEGACY_SPEED_CODE   = 3'h7;
	localparam logic [3:0] REPEATER_DELAY_CODE = 4'hf;
	localparam logic [5:0] GAP_COUNT_RESET     = 6'h3f;
	localparam logic [7:0] RESET_REG_WRITABLE  = 8'h00;

	// ----------
	// timing
	// ----------
	localparam int CLK_PERIOD_NS         = 10;
	localparam int LONG_RESET_TIME_US    = 166;
	localparam int LONG_RESET_CYCLES     = (LONG_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int LONG_RESET_CNT_WIDTH  = 15;

	// ----------
	// axi response codes
	// ----------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------
	// carriers
	// ----------
	// configuration packet seen on the bus (received or sent)
	typedef struct packed {
		logic       valid;
		logic       set_root_holdoff;
		logic       root_holdoff;
		logic       set_gap_count;
		logic [5:0] gap_count;
	} sbr_config_pkt_t;

	// events reported by the arbitration / tree logic
	typedef struct packed {
		logic       bus_reset;
		logic       tree_id_root;
		logic       self_id_done;
		logic [5:0] phys_address;
	} sbr_bus_event_t;

	// requests going out to the phy core
	typedef struct packed {
		logic       long_reset_active;
		logic       short_reset_request;
		logic       root_holdoff;
		logic       standby_restore_enable;
		logic [5:0] gap_count;
		logic [2:0] page_select;
		logic [3:0] port_select;
	} sbr_core_ctrl_t;

endpackage : sbr_pkg

// ### logic/sbr_long_reset_timer.sv
// module: long bus reset sequencer, waits for idle link then drives reset for a fixed time
`timescale 1ns/100ps

module sbr_long_reset_timer
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic link_busy,
	output logic      active,
	output logic      done
);

	// ----------
	// state
	// ----------
	typedef enum logic [1:0]
	{
		SBR_LR_IDLE = 2'b00,
		SBR_LR_WAIT = 2'b01,
		SBR_LR_RUN  = 2'b10
	} sbr_lr_state_t;

	localparam logic [sbr_pkg::LONG_RESET_CNT_WIDTH-1:0] LAST_COUNT =
		sbr_pkg::LONG_RESET_CNT_WIDTH'(sbr_pkg::LONG_RESET_CYCLES - 1);

	sbr_lr_state_t                             state;
	sbr_lr_state_t                             next_state;
	logic [sbr_pkg::LONG_RESET_CNT_WIDTH-1:0]  count;
	logic                                      count_end;

	assign count_end = (count == LAST_COUNT);
	assign active    = (state == SBR_LR_RUN);
	assign done      = active && count_end;

	// next state: a transfer in flight must finish before reset goes out [RULE6]
	always_comb
	begin
		next_state = state;
		unique case (state)
			SBR_LR_IDLE: if (start) next_state = SBR_LR_WAIT;
			SBR_LR_WAIT: if (!link_busy) next_state = SBR_LR_RUN;
			SBR_LR_RUN:  if (count_end) next_state = SBR_LR_IDLE;
			default:     next_state = SBR_LR_IDLE;
		endcase
	end

	// state and 166 us duration counter [RULE6]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= SBR_LR_IDLE;
			count <= '0;
		end
		else
		begin
			state <= next_state;
			count <= active ? count + 1'b1 : '0;
		end
	end

endmodule : sbr_long_reset_timer

// ### logic/sbr_base_regs.sv
// module: phy base register bank 0..7 with an axi4-lite slave
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: node address is read only, updated at self-id end with unsolicited status pulse.
// RULE2: root flag clears on every bus reset, sets when tree-id makes us root.
// RULE3: cable power status bit follows synchronised sense input; zero means supply low.
// RULE4: root holdoff asks for root next bus reset; hardware reset clears, bus reset keeps.
// RULE5: controller should change root holdoff only by configuration packet.
// RULE6: long reset request starts 166 us reset after ongoing transfer completes.
// RULE7: long reset request clears on hardware reset and on any bus reset.
// RULE8: controller keeps other bits when writing long reset request; short reset preferred.
// RULE9: gap count is loaded by register write or configuration packet; drives gap timing.
// RULE10: gap count resets to 3f on hardware reset or two resets without a write.
// RULE11: controller should change gap count by configuration packets, not register writes.
// RULE12: extended set code reads 111b.
// RULE13: port count field reads 3.
// RULE14: legacy speed code reads all ones.
// RULE15: standby restore enable lets local ports enter standby on command.
// RULE16: repeater delay field reads f.
// RULE17: eight byte registers at 0..7, documented bit 0 is the most significant bit.
// RULE18: reserved registers and fields read zero.
// RULE19: page select picks the paged window; base registers are page independent.
// RULE20: writes to read-only fields are ignored.
module sbr_base_regs
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// axi4-lite slave
	input  wire logic [5:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [5:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// phy core side
	input  wire logic                     cable_power_sense,
	input  wire logic                     link_busy,
	input  wire sbr_pkg::sbr_bus_event_t  bus_event,
	input  wire sbr_pkg::sbr_config_pkt_t config_pkt,
	input  wire logic [7:0]               paged_rdata,
	output sbr_pkg::sbr_core_ctrl_t       core_ctrl,
	output logic                          long_reset_done,
	output logic                          status_reg0_push,
	output logic [7:0]                    status_reg0_data
);

	// ----------
	// storage
	// ----------
	logic [5:0] node_phys_address;
	logic       root;
	logic       cps_meta;
	logic       cable_power_status;
	logic       root_holdoff;
	logic       long_bus_reset_request;
	logic [5:0] gap_count;
	logic       gap_written;
	logic       standby_restore_enable;
	logic [7:0] link_contender_power;
	logic [7:0] interrupt_event_control;
	logic [7:0] legacy_speed_bridge;
	logic [2:0] page_select;
	logic [3:0] port_select;
	logic       long_reset_active;

	// ----------
	// axi write channel
	// ----------
	logic       aw_held;
	logic [5:0] aw_addr;
	logic       w_held;
	logic [7:0] w_byte;
	logic       w_lane0;
	logic       wr_fire;
	logic       wr_base;
	logic [2:0] wr_idx;
	logic       wr_en;

	// accept address and data in any order, one write outstanding
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held;
	assign wr_base       = (aw_addr < sbr_pkg::ADDR_PAGED_BASE);
	assign wr_idx        = aw_addr[4:2];
	// only byte lane 0 carries data; other lanes are ignored
	assign wr_en         = wr_fire && wr_base && w_lane0;

	// hold address and data until both are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_byte       <= '0;
			w_lane0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sbr_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held  <= 1'b1;
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_base ? sbr_pkg::RESP_OKAY : sbr_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------
	// write decode per register
	// ----------
	logic wr_reg1;
	logic wr_reg3;
	logic wr_reg4;
	logic wr_reg5;
	logic wr_reg6;
	logic wr_reg7;

	// registers 0 and 2 have no write enable at all [RULE20]
	assign wr_reg1 = wr_en && (wr_idx == sbr_pkg::IDX_RESET_GAP_CONTROL);
	assign wr_reg3 = wr_en && (wr_idx == sbr_pkg::IDX_SPEED_STANDBY_DELAY);
	assign wr_reg4 = wr_en && (wr_idx == sbr_pkg::IDX_LINK_CONTENDER_POWER);
	assign wr_reg5 = wr_en && (wr_idx == sbr_pkg::IDX_INTERRUPT_EVENT_CONTROL);
	assign wr_reg6 = wr_en && (wr_idx == sbr_pkg::IDX_LEGACY_SPEED_BRIDGE);
	assign wr_reg7 = wr_en && (wr_idx == sbr_pkg::IDX_PAGE_PORT_SELECT);

	// ----------
	// cable power sense synchroniser
	// ----------
	// the sense pin is asynchronous, two flops before use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cps_meta           <= 1'b0;
			cable_power_status <= 1'b0;
		end
		else
		begin
			cps_meta           <= cable_power_sense;
			cable_power_status <= cps_meta; // [RULE3]
		end
	end

	// ----------
	// register 0: address and root
	// ----------
	// address only valid once self-id is over, then report it unsolicited
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			node_phys_address <= '0;
			root              <= 1'b0;
			status_reg0_push  <= 1'b0;
		end
		else
		begin
			status_reg0_push <= bus_event.self_id_done; // [RULE1]
			if (bus_event.self_id_done)
				node_phys_address <= bus_event.phys_address; // [RULE1]
			if (bus_event.bus_reset)
				root <= 1'b0; // [RULE2]
			else if (bus_event.tree_id_root)
				root <= 1'b1; // [RULE2]
		end
	end

	// ----------
	// register 1: root holdoff, long reset request, gap count
	// ----------
	logic       cfg_gap;
	logic       gap_load;
	logic [5:0] next_gap_count;
	logic       lr_start;

	assign cfg_gap  = config_pkt.valid && config_pkt.set_gap_count;
	assign gap_load = wr_reg1 || cfg_gap;
	// a configuration packet wins over a register write in the same cycle
	assign next_gap_count = cfg_gap ? config_pkt.gap_count
		: w_byte[sbr_pkg::POS_GAP_COUNT +: 6];
	// a fresh write of the request bit launches the long reset sequence
	assign lr_start = wr_reg1 && w_byte[sbr_pkg::POS_LONG_BUS_RESET_REQUEST]
		&& !long_bus_reset_request;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			root_holdoff           <= 1'b0; // [RULE4]
			long_bus_reset_request <= 1'b0; // [RULE7]
			gap_count              <= sbr_pkg::GAP_COUNT_RESET; // [RULE10]
			gap_written            <= 1'b0;
		end
		else
		begin
			// holdoff survives bus resets; packets outrank register writes [RULE4]
			if (config_pkt.valid && config_pkt.set_root_holdoff)
				root_holdoff <= config_pkt.root_holdoff;
			else if (wr_reg1)
				root_holdoff <= w_byte[sbr_pkg::POS_ROOT_HOLDOFF];
			// any bus reset, including our own, drops the request [RULE7]
			if (bus_event.bus_reset || long_reset_done)
				long_bus_reset_request <= 1'b0;
			else if (wr_reg1)
				long_bus_reset_request <= w_byte[sbr_pkg::POS_LONG_BUS_RESET_REQUEST];
			// second bus reset without a load restores the default [RULE10]
			if (gap_load)
			begin
				gap_count   <= next_gap_count; // [RULE9]
				gap_written <= 1'b1;
			end
			else if (bus_event.bus_reset)
			begin
				gap_written <= 1'b0;
				if (!gap_written)
					gap_count <= sbr_pkg::GAP_COUNT_RESET; // [RULE10]
			end
		end
	end

	// long reset timer waits for idle link then times 166 us [RULE6]
	sbr_long_reset_timer u_long_reset
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (lr_start),
		.link_busy (link_busy),
		.active    (long_reset_active),
		.done      (long_reset_done)
	);

	// ----------
	// registers 3..7: writable fields
	// ----------
	// short reset request sits in register 5 bit 1 and clears on bus reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			standby_restore_enable  <= 1'b0;
			link_contender_power    <= sbr_pkg::RESET_REG_WRITABLE;
			interrupt_event_control <= sbr_pkg::RESET_REG_WRITABLE;
			legacy_speed_bridge     <= sbr_pkg::RESET_REG_WRITABLE;
			page_select             <= '0;
			port_select             <= '0;
		end
		else
		begin
			if (wr_reg3)
				standby_restore_enable <= w_byte[sbr_pkg::POS_STANDBY_RESTORE_ENABLE];
			if (wr_reg4)
				link_contender_power <= w_byte;
			if (bus_event.bus_reset)
				interrupt_event_control[6] <= 1'b0;
			else if (wr_reg5)
				interrupt_event_control <= w_byte;
			if (wr_reg6)
				legacy_speed_bridge <= {w_byte[7:2], 2'b00}; // [RULE18]
			if (wr_reg7)
			begin
				page_select <= w_byte[sbr_pkg::POS_PAGE_SELECT +: 3]; // [RULE19]
				port_select <= w_byte[sbr_pkg::POS_PORT_SELECT +: 4];
			end
		end
	end

	// ----------
	// read image of the base bank
	// ----------
	logic [7:0] reg_image [sbr_pkg::REG_COUNT];

	// documented bit 0 is our bit 7; fixed codes are constants [RULE17]
	assign reg_image[0] = {node_phys_address, root, cable_power_status}; // [RULE1] [RULE3]
	assign reg_image[1] = {root_holdoff, long_bus_reset_request, gap_count};
	assign reg_image[2] = {sbr_pkg::EXTENDED_SET_CODE, 1'b0,
		sbr_pkg::PORT_COUNT_CODE}; // [RULE12] [RULE13] [RULE18]
	assign reg_image[3] = {sbr_pkg::LEGACY_SPEED_CODE, standby_restore_enable,
		sbr_pkg::REPEATER_DELAY_CODE}; // [RULE14] [RULE16]
	assign reg_image[4] = link_contender_power;
	assign reg_image[5] = interrupt_event_control;
	assign reg_image[6] = legacy_speed_bridge;
	assign reg_image[7] = {page_select, 1'b0, port_select}; // [RULE18]

	// ----------
	// axi read channel
	// ----------
	logic       rd_fire;
	logic       rd_base;
	logic [7:0] rd_byte;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rd_base       = (s_axi_araddr < sbr_pkg::ADDR_PAGED_BASE);
	// paged window 8..f comes from the selected page in the core [RULE19]
	assign rd_byte       = rd_base ? reg_image[s_axi_araddr[4:2]] : paged_rdata;

	// one read at a time, answer one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= sbr_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_byte}; // [RULE18]
			s_axi_rresp  <= sbr_pkg::RESP_OKAY;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------
	// outputs to the core
	// ----------
	assign status_reg0_data                 = reg_image[0];
	assign core_ctrl.long_reset_active      = long_reset_active; // [RULE6]
	assign core_ctrl.short_reset_request    = interrupt_event_control[6];
	assign core_ctrl.root_holdoff           = root_holdoff; // [RULE4]
	assign core_ctrl.standby_restore_enable = standby_restore_enable; // [RULE15]
	assign core_ctrl.gap_count              = gap_count; // [RULE9]
	assign core_ctrl.page_select            = page_select; // [RULE19]
	assign core_ctrl.port_select            = port_select;

endmodule : sbr_base_regs

// ### sim/sbr_base_regs_asserts.sv
// checker: concurrent properties on the ports of the base register bank
`timescale 1ns/100ps

module sbr_base_regs_asserts
(
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_bvalid,
	input wire logic                     cable_power_sense,
	input wire logic                     link_busy,
	input wire sbr_pkg::sbr_bus_event_t  bus_event,
	input wire sbr_pkg::sbr_config_pkt_t config_pkt,
	input wire sbr_pkg::sbr_core_ctrl_t  core_ctrl,
	input wire logic                     long_reset_done,
	input wire logic                     status_reg0_push,
	input wire logic [7:0]               status_reg0_data
);
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [14:0] act_cnt;

	// cycles spent in the long reset; too long a span to unroll
	always_ff @(posedge aclk)
		act_cnt <= (core_ctrl.long_reset_active && aresetn) ? act_cnt + 15'h1 : 15'h0;

	property p_push;
		bus_event.self_id_done |=> status_reg0_push;
	endproperty
	a_push: assert property (p_push) else $error("no status push after self id");
	property p_root;
		bus_event.bus_reset && !bus_event.tree_id_root |=> !status_reg0_data[1];
	endproperty
	a_root: assert property (p_root) else $error("root flag kept over bus reset");
	property p_cps;
		($stable(cable_power_sense))[*4] |-> status_reg0_data[0] == cable_power_sense;
	endproperty
	a_cps: assert property (p_cps) else $error("power status not following sense");
	property p_hold;
		config_pkt.valid && config_pkt.set_root_holdoff
			|=> core_ctrl.root_holdoff == $past(config_pkt.root_holdoff);
	endproperty
	a_hold: assert property (p_hold) else $error("holdoff not loaded by packet");
	property p_hold_keep;
		bus_event.bus_reset && !config_pkt.valid
			|=> $stable(core_ctrl.root_holdoff) || $rose(s_axi_bvalid);
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("holdoff moved on bus reset");
	property p_gap;
		config_pkt.valid && config_pkt.set_gap_count
			|=> core_ctrl.gap_count == $past(config_pkt.gap_count);
	endproperty
	a_gap: assert property (p_gap) else $error("gap count not loaded by packet");
	property p_len;
		long_reset_done |-> core_ctrl.long_reset_active
			&& act_cnt == sbr_pkg::LONG_RESET_CYCLES - 1;
	endproperty
	a_len: assert property (p_len) else $error("long reset length wrong");
	property p_end;
		$past(aresetn) && $fell(core_ctrl.long_reset_active) |-> $past(long_reset_done);
	endproperty
	a_end: assert property (p_end) else $error("long reset ended without done");
	property p_busy;
		$rose(core_ctrl.long_reset_active) |-> !$past(link_busy);
	endproperty
	a_busy: assert property (p_busy) else $error("long reset cut into a transfer");
	property p_rhi;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rhi: assert property (p_rhi) else $error("upper read bits not zero");
endmodule : sbr_base_regs_asserts

bind sbr_base_regs sbr_base_regs_asserts sbr_base_regs_asserts_inst (.aclk, .aresetn,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .cable_power_sense, .link_busy, .bus_event,
	.config_pkt, .core_ctrl, .long_reset_done, .status_reg0_push, .status_reg0_data);

// ### sim/sbr_core_model.sv
// model: phy core and bus events around the base register bank
`timescale 1ns/100ps

module sbr_core_model
(
	input  wire logic                    aclk,
	input  wire sbr_pkg::sbr_core_ctrl_t core_ctrl,
	input  wire logic                    long_reset_done,
	output logic                         link_busy,
	output logic                         cable_power_sense,
	output sbr_pkg::sbr_bus_event_t      bus_event,
	output sbr_pkg::sbr_config_pkt_t     config_pkt,
	output logic [7:0]                   paged_rdata
);
	logic       br, br_tail, root_p, sid_p;
	logic [5:0] addr;

	// a finished long reset reaches the bank as a bus reset one cycle later
	always @(posedge aclk)
		br_tail <= long_reset_done;
	assign bus_event = {br | br_tail, root_p, sid_p, addr};
	// page number in the low bits so a read proves which page was chosen
	assign paged_rdata = {5'h0a, core_ctrl.page_select};

	// idle bus, cable power present
	initial
	begin
		{br, root_p, sid_p, link_busy} = 4'h0;
		addr = 6'h0;
		cable_power_sense = 1'b1;
		config_pkt = '0;
	end

	task automatic bus_reset();
		@(posedge aclk);
		br <= 1'b1;
		@(posedge aclk);
		br <= 1'b0;
	endtask : bus_reset

	task automatic self_id(input logic [5:0] a, input logic r);
		@(posedge aclk);
		root_p <= r;
		addr   <= a;
		@(posedge aclk);
		root_p <= 1'b0;
		sid_p  <= 1'b1;
		@(posedge aclk);
		sid_p  <= 1'b0;
	endtask : self_id

	// holdoff and gap reach the bank this way or by a register 1 write
	task automatic cfg(input logic h, input logic [5:0] g);
		@(posedge aclk);
		config_pkt <= {1'b1, 1'b1, h, 1'b1, g};
		@(posedge aclk);
		config_pkt <= '0;
	endtask : cfg
endmodule : sbr_core_model

// ### sim/testbench.sv
// testbench: register access sequences with expected values for the base bank
`timescale 1ns/100ps

module testbench;
	logic                     aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic                     s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic                     s_axi_bvalid, s_axi_arready, s_axi_rvalid, link_busy;
	logic                     cable_power_sense, long_reset_done, status_reg0_push;
	logic [5:0]               s_axi_awaddr, s_axi_araddr;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic [7:0]               paged_rdata, status_reg0_data;
	sbr_pkg::sbr_bus_event_t  bus_event;
	sbr_pkg::sbr_config_pkt_t config_pkt;
	sbr_pkg::sbr_core_ctrl_t  core_ctrl;
	int                       err_count, tests_run;
	localparam logic [7:0]    RST_VAL [8] = '{8'h01, 8'h3f, 8'he3, 8'hef, 8'h0, 8'h0, 8'h0, 8'h0};

	sbr_base_regs sbr_base_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cable_power_sense, .link_busy,
		.bus_event, .config_pkt, .paged_rdata, .core_ctrl, .long_reset_done, .status_reg0_push,
		.status_reg0_data);
	sbr_core_model sbr_core_model_inst (.aclk, .core_ctrl, .long_reset_done, .link_busy,
		.cable_power_sense, .bus_event, .config_pkt, .paged_rdata);

	// 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// sample at the falling edge, clear of the slave's flop updates
	task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [31:0] resp);
		logic aw, w, b;
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= {24'h0, d};
		s_axi_wvalid  <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge aclk);
			aw   = s_axi_awvalid && s_axi_awready;
			w    = s_axi_wvalid && s_axi_wready;
			b    = s_axi_bvalid;
			resp = {30'h0, s_axi_bresp};
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		logic ar, v;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		v = 1'b0;
		while (!v)
		begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			v  = s_axi_rvalid;
			d  = s_axi_rdata[7:0];
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
	endtask : rd

	task automatic chkr(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk({24'h0, d}, {24'h0, exp});
	endtask : chkr

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// watchdog: the long reset dominates, about 17000 cycles
	initial
	begin
		repeat (40000) @(posedge aclk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end

	// main sequence
	initial
	begin
		logic [31:0] r;
		logic [7:0]  d;
		int          cnt;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {12'h0, 32'h0, 4'h1};
		err_count = 0;
		tests_run = 0;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < 8; i++)
			chkr(6'(4 * i), RST_VAL[i]);
		$display("test reset values done");
		wr(6'h00, 8'hfe, r);
		chkr(6'h00, 8'h01);
		wr(6'h08, 8'h00, r);
		chkr(6'h08, 8'he3);
		wr(6'h0c, 8'h10, r);
		chkr(6'h0c, 8'hff);
		chk({31'h0, core_ctrl.standby_restore_enable}, 32'h1);
		wr(6'h0c, 8'he0, r);
		chkr(6'h0c, 8'hef);
		wr(6'h18, 8'hff, r);
		chkr(6'h18, 8'hfc);
		wr(6'h1c, 8'hff, r);
		chkr(6'h1c, 8'hef);
		chk({28'h0, core_ctrl.port_select}, 32'hf);
		chkr(6'h24, 8'h57);
		chkr(6'h04, 8'h3f);
		wr(6'h24, 8'h00, r);
		chk(r, 32'h2);
		wr(6'h1c, 8'h00, r);
		wr(6'h14, 8'h40, r);
		chk({31'h0, core_ctrl.short_reset_request}, 32'h1);
		$display("test access kinds done");
		sbr_core_model_inst.cfg(1'b1, 6'h05);
		chkr(6'h04, 8'h85);
		sbr_core_model_inst.bus_reset();
		chkr(6'h04, 8'h85);
		chkr(6'h14, 8'h00);
		sbr_core_model_inst.bus_reset();
		chkr(6'h04, 8'hbf);
		wr(6'h04, 8'h8a, r);
		sbr_core_model_inst.bus_reset();
		wr(6'h04, 8'h8a, r);
		sbr_core_model_inst.bus_reset();
		chkr(6'h04, 8'h8a);
		sbr_core_model_inst.bus_reset();
		chkr(6'h04, 8'hbf);
		$display("test gap and holdoff done");
		sbr_core_model_inst.self_id(6'h2a, 1'b1);
		chkr(6'h00, 8'hab);
		sbr_core_model_inst.bus_reset();
		rd(6'h00, d);
		chk({24'h0, d & 8'h02}, 32'h0);
		sbr_core_model_inst.cable_power_sense <= 1'b0;
		repeat (4) @(posedge aclk);
		rd(6'h00, d);
		chk({24'h0, d & 8'h01}, 32'h0);
		sbr_core_model_inst.cable_power_sense <= 1'b1;
		$display("test node status done");
		sbr_core_model_inst.link_busy <= 1'b1;
		wr(6'h04, 8'hff, r);
		chkr(6'h04, 8'hff);
		sbr_core_model_inst.bus_reset();
		chkr(6'h04, 8'hbf);
		wr(6'h04, 8'hff, r);
		repeat (20) @(posedge aclk);
		chk({31'h0, core_ctrl.long_reset_active}, 32'h0);
		sbr_core_model_inst.link_busy <= 1'b0;
		cnt = 0;
		while (long_reset_done !== 1'b1)
		begin
			@(negedge aclk);
			if (core_ctrl.long_reset_active === 1'b1)
				cnt++;
		end
		chk(cnt, sbr_pkg::LONG_RESET_CYCLES);
		@(posedge aclk);
		chkr(6'h04, 8'hbf);
		$display("test long reset done");
		summarize();
	end
endmodule : testbench
